//--- acgpio_pkg.sv
/*
  package for the connector general_purpose_pins block: register offsets,
  field positions, reset values and the carrier structs.
  assumes a 32-bit local bus with byte addresses in the runtime_local_window.
*/
package acgpio_pkg;
  localparam logic [7:0] OFS_IRQ_MASK = 8'he0;
  localparam logic [7:0] OFS_PIN_DATA = 8'he4;
  localparam logic [7:0] OFS_DIRECTION = 8'he8;
  localparam logic [7:0] OFS_EDGE_STATUS = 8'hec;

  localparam int NUM_PINS = 2;
  localparam int MASK_BITS = 6;
  // mask field positions (pin 1 at the low bit of each pair)
  localparam int MASK_OUT_POS = 0;
  localparam int MASK_RISE_POS = 2;
  localparam int MASK_FALL_POS = 4;
  // status field positions
  localparam int STAT_RISE_POS = 2;
  localparam int STAT_FALL_POS = 4;

  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic [1:0] DATA_RESET = 2'h0;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } acgpio_req_t;

  typedef struct packed {
    logic [1:0] rise;
    logic [1:0] fall;
  } acgpio_edge_t;
endpackage : acgpio_pkg

//--- acgpio_edge_det.sv
/*
  two-flop synchroniser and edge detector for the connector pins.
  assumes pins are sampled in the clk domain.
*/
`timescale 1ns/100ps
module acgpio_edge_det (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins
  input wire logic [1:0] pinIn,
  // results
  output logic [1:0] pinSync,
  output acgpio_pkg::acgpio_edge_t edges
);
  logic [1:0] meta_r, meta_nxt;
  logic [1:0] sync_r, sync_nxt;
  logic [1:0] prev_r, prev_nxt;

  always_comb begin
    meta_nxt = pinIn;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // first flop is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign pinSync = sync_r;
  assign edges.rise = sync_r & ~prev_r;
  assign edges.fall = ~sync_r & prev_r;
endmodule : acgpio_edge_det

//--- acgpio_top.sv
/*
  connector general_purpose_pins: two pins with direction, output data,
  mask and read-to-clear edge status merged into the local-bus interrupt.
  assumes single-cycle register strobes synchronous to clk and the board's
  other interrupt sources arriving as one level.
*/
// What this block does
// - mask register has six used bits, all reset to masked (zero)
// - mask bits 0 and 1 gate pin 1 and pin 2 output data
// - mask bits 2 and 3 enable rising-edge interrupts of pins 1 and 2
// - mask bits 4 and 5 enable falling-edge interrupts of pins 1 and 2
// - data write stores two bits; drives pin only when direction is output
// - data read returns live pin levels, not the written value
// - data bit 0 is pin 1, bit 1 is pin 2, higher bits reserved
// - direction bit per pin, zero input, one output
// - after reset both pins are inputs with drivers off
// - status reports edges only for input pins, and only unmasked ones
// - reading status returns its value then clears every status bit not set again by an edge in that same cycle
// - status bits 2..5: pin1 rise, pin2 rise, pin1 fall, pin2 fall
// - active edge status ORs with other board interrupts onto one request
`timescale 1ns/100ps
module acgpio_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register access
  input wire acgpio_pkg::acgpio_req_t req,
  output logic [31:0] rdata,
  // connector pins
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  // interrupt
  input wire logic otherIrq,
  output logic localIrq
);
  logic [5:0] mask_r, mask_nxt;
  logic [1:0] data_r, data_nxt;
  logic [1:0] dir_r, dir_nxt;
  logic [5:0] stat_r, stat_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] pinSync;
  acgpio_pkg::acgpio_edge_t edges;
  logic [5:0] evt;

  function automatic logic hit(input acgpio_pkg::acgpio_req_t r, input logic [7:0] ofs);
    hit = r.sel && (r.addr == ofs);
  endfunction : hit

  acgpio_edge_det acgpio_edge_det_i (
    .clk(clk),
    .arst_n(arst_n),
    .pinIn(pinIn),
    .pinSync(pinSync),
    .edges(edges)
  );

  // ----------------------------------------------------------------
  // edge events
  // ----------------------------------------------------------------
  // masked events are dropped, not just hidden, so status never carries them
  always_comb begin
    evt = 6'h00;
    evt[acgpio_pkg::STAT_RISE_POS +: 2] = edges.rise & ~dir_r
      & mask_r[acgpio_pkg::MASK_RISE_POS +: 2];
    evt[acgpio_pkg::STAT_FALL_POS +: 2] = edges.fall & ~dir_r
      & mask_r[acgpio_pkg::MASK_FALL_POS +: 2];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_comb begin
    mask_nxt = mask_r;
    data_nxt = data_r;
    dir_nxt = dir_r;
    stat_nxt = stat_r;
    rdata_nxt = rdata_r;
    if (req.wr && hit(req, acgpio_pkg::OFS_IRQ_MASK)) begin
      mask_nxt = req.wdata[5:0];
    end
    if (req.wr && hit(req, acgpio_pkg::OFS_PIN_DATA)) begin
      data_nxt = req.wdata[1:0];
    end
    if (req.wr && hit(req, acgpio_pkg::OFS_DIRECTION)) begin
      dir_nxt = req.wdata[1:0];
    end
    if (req.rd) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(req, acgpio_pkg::OFS_IRQ_MASK)) begin
        rdata_nxt[5:0] = mask_r;
      end else if (hit(req, acgpio_pkg::OFS_PIN_DATA)) begin
        rdata_nxt[1:0] = pinSync;
      end else if (hit(req, acgpio_pkg::OFS_DIRECTION)) begin
        rdata_nxt[1:0] = dir_r;
      end else if (hit(req, acgpio_pkg::OFS_EDGE_STATUS)) begin
        rdata_nxt[5:0] = stat_r;
        stat_nxt = 6'h00;
      end
    end
    // set wins over the read clear
    stat_nxt = stat_nxt | evt;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= acgpio_pkg::MASK_RESET;
      data_r <= acgpio_pkg::DATA_RESET;
      dir_r <= acgpio_pkg::DIR_RESET;
      stat_r <= 6'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      mask_r <= mask_nxt;
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a masked output pin drives low while still enabled
  assign pinOut = data_r & mask_r[acgpio_pkg::MASK_OUT_POS +: 2];
  assign pinOe = dir_r;
  assign localIrq = (|stat_r) | otherIrq;
  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_stat_read;
    req.rd && hit(req, acgpio_pkg::OFS_EDGE_STATUS);
  endsequence

  chk_mask_reset: assert property (@(posedge clk) $rose(arst_n) |-> mask_r == 6'h00)
    else $error("mask not reset to masked");
  chk_out_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !mask_r[0] |-> !pinOut[0])
    else $error("masked pin 1 output driven high");
  chk_rise_masked: assert property (@(posedge clk) disable iff (!arst_n)
    (edges.rise[0] && !mask_r[2] && !stat_r[2]) |=> !stat_r[2])
    else $error("masked rising edge set status");
  chk_fall_set: assert property (@(posedge clk) disable iff (!arst_n)
    (edges.fall[1] && mask_r[5] && !dir_r[1]) |=> stat_r[5])
    else $error("unmasked falling edge lost");
  chk_data_store: assert property (@(posedge clk) disable iff (!arst_n)
    (req.wr && hit(req, acgpio_pkg::OFS_PIN_DATA)) |=> data_r == $past(req.wdata[1:0]))
    else $error("data write not stored");
  chk_data_read: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && hit(req, acgpio_pkg::OFS_PIN_DATA)) |=> rdata[1:0] == $past(pinSync))
    else $error("data read not live pins");
  chk_dir_drive: assert property (@(posedge clk) disable iff (!arst_n)
    pinOe == dir_r)
    else $error("output enable differs from direction");
  chk_out_input: assert property (@(posedge clk) disable iff (!arst_n)
    (edges.rise[1] && dir_r[1] && !stat_r[3]) |=> !stat_r[3])
    else $error("output pin reported an edge");
  chk_read_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (s_stat_read ##0 (evt == 6'h00)) |=> (stat_r == 6'h00) && (rdata[5:0] == $past(stat_r)))
    else $error("status read did not clear");
  chk_irq_merge: assert property (@(posedge clk) disable iff (!arst_n)
    localIrq == ((|stat_r) || otherIrq))
    else $error("interrupt merge wrong");

  // ----------------------------------------------------------------
  // checks on writes, reads and pin sampling
  // ----------------------------------------------------------------
  // a synchronised level that flips between two edges marks one pin edge
  sequence s_pin1_rise;
    !pinSync[0] ##1 pinSync[0];
  endsequence

  sequence s_pin1_fall;
    pinSync[0] ##1 !pinSync[0];
  endsequence

  sequence s_mask_write;
    req.wr && hit(req, acgpio_pkg::OFS_IRQ_MASK);
  endsequence

  sequence s_dir_write;
    req.wr && hit(req, acgpio_pkg::OFS_DIRECTION);
  endsequence

  sequence s_mask_read;
    req.rd && hit(req, acgpio_pkg::OFS_IRQ_MASK);
  endsequence

  chk_out_gate_p2: assert property (@(posedge clk) disable iff (!arst_n)
    !mask_r[1] |-> !pinOut[1])
    else $error("masked pin 2 output driven high");
  chk_rise_set: assert property (@(posedge clk) disable iff (!arst_n)
    (s_pin1_rise ##0 (mask_r[2] && !dir_r[0])) |=> stat_r[2])
    else $error("unmasked pin 1 rising edge lost");
  chk_rise_p2: assert property (@(posedge clk) disable iff (!arst_n)
    (edges.rise[1] && mask_r[3] && !dir_r[1]) |=> stat_r[3])
    else $error("unmasked pin 2 rising edge lost");
  chk_fall_p1: assert property (@(posedge clk) disable iff (!arst_n)
    (s_pin1_fall ##0 (mask_r[4] && !dir_r[0])) |=> stat_r[4])
    else $error("unmasked pin 1 falling edge lost");
  chk_fall_masked: assert property (@(posedge clk) disable iff (!arst_n)
    (edges.fall[0] && !mask_r[4] && !stat_r[4]) |=> !stat_r[4])
    else $error("masked falling edge set status");
  chk_reset_idle: assert property (@(posedge clk) $rose(arst_n) |->
    (pinOe == 2'h0) && (localIrq == otherIrq))
    else $error("pins or interrupt not idle after reset");
  chk_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_mask_write |=> mask_r == $past(req.wdata[5:0]))
    else $error("mask write not stored");
  chk_mask_read: assert property (@(posedge clk) disable iff (!arst_n)
    s_mask_read |=> rdata[5:0] == $past(mask_r))
    else $error("mask read wrong");
  chk_dir_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_dir_write |=> dir_r == $past(req.wdata[1:0]))
    else $error("direction write not stored");
  chk_read_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd |=> rdata[31:6] == 26'h0)
    else $error("reserved read bits not zero");
  // the lag is only defined once the synchroniser has run two edges out of reset
  chk_sync_delay: assert property (@(posedge clk) disable iff (!arst_n)
    $past(arst_n, 2) |-> pinSync == $past(pinIn, 2))
    else $error("pin not synchronised in two cycles");
  chk_stat_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !(req.rd && hit(req, acgpio_pkg::OFS_EDGE_STATUS)) |=> ((stat_r & $past(stat_r)) == $past(stat_r)))
    else $error("status bit lost without a read");
endmodule : acgpio_top

//--- acgpio_ext_model.sv
/*
  external equipment wired to the two connector pins.
  assumes the bench sets extLevel away from the rising clock edge.
*/
`timescale 1ns/100ps
module acgpio_ext_model (
  // from the block
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  // far side level and resolved wire
  input wire logic [1:0] extLevel,
  output logic [1:0] pinIn
);
  // a driven pin shows the block's level, a released one the far side's
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : acgpio_ext_model

//--- acgpio_top_tb_top.sv
/*
  self-checking bench for the connector pin block.
  assumes the pin model resolves the wire and register strobes last one cycle.
*/
`timescale 1ns/100ps
module acgpio_top_tb_top;
  logic clk, arst_n, otherIrq, localIrq;
  logic [1:0] extLevel, pinIn, pinOut, pinOe;
  logic [31:0] rdata;
  acgpio_pkg::acgpio_req_t req;
  int error_cnt, checks_done, cycles;

  acgpio_top acgpio_top_i (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .otherIrq(otherIrq), .localIrq(localIrq));
  acgpio_ext_model acgpio_ext_model_i (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // one access; rdata is settled at the falling edge that ends it
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = {1'b1, w, ~w, a, d};
    @(negedge clk);
    req = '0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(exp, rdata);
  endtask : rd

  task automatic pins(input logic [1:0] v);
    extLevel = v;
    repeat (4) @(negedge clk);
  endtask : pins

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(acgpio_pkg::OFS_IRQ_MASK, 32'h0);
    rd(acgpio_pkg::OFS_DIRECTION, 32'h0);
    chk(32'(pinOe), 32'h0);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'hffffffff);
    rd(acgpio_pkg::OFS_IRQ_MASK, 32'h3f);
    rd(8'hf0, 32'h0);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_output();
    acc(1'b1, acgpio_pkg::OFS_PIN_DATA, 32'h3);
    acc(1'b1, acgpio_pkg::OFS_DIRECTION, 32'h3);
    chk(32'(pinOe), 32'h3);
    chk(32'(pinOut), 32'h0);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h1);
    chk(32'(pinOut), 32'h1);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h3);
    pins(2'b00);
    rd(acgpio_pkg::OFS_PIN_DATA, 32'h3);
    acc(1'b1, acgpio_pkg::OFS_DIRECTION, 32'h1);
    pins(2'b00);
    rd(acgpio_pkg::OFS_PIN_DATA, 32'h1);
    $display("test output done");
  endtask : t_output

  task automatic t_edges();
    acc(1'b1, acgpio_pkg::OFS_DIRECTION, 32'h0);
    // pin 1 falls as it is released; let that edge pass while still masked
    pins(2'b00);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h3c);
    pins(2'b00);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h0);
    pins(2'b11);
    chk(32'(localIrq), 32'h1);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'hc);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h0);
    chk(32'(localIrq), 32'h0);
    pins(2'b01);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h20);
    pins(2'b00);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h10);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h08);
    pins(2'b11);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h8);
    acc(1'b1, acgpio_pkg::OFS_IRQ_MASK, 32'h3d);
    acc(1'b1, acgpio_pkg::OFS_DIRECTION, 32'h1);
    acc(1'b1, acgpio_pkg::OFS_PIN_DATA, 32'h0);
    pins(2'b10);
    acc(1'b1, acgpio_pkg::OFS_PIN_DATA, 32'h1);
    pins(2'b10);
    rd(acgpio_pkg::OFS_EDGE_STATUS, 32'h0);
    otherIrq = 1'b1;
    #1;
    chk(32'(localIrq), 32'h1);
    @(negedge clk);
    otherIrq = 1'b0;
    $display("test edges done");
  endtask : t_edges

  initial begin
    arst_n = 1'b0;
    otherIrq = 1'b0;
    extLevel = 2'b00;
    req = '0;
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_output();
    t_edges();
    test_done();
  end
endmodule : acgpio_top_tb_top
